// file: common/host_bus_if.sv
`timescale 1ns/1ps
interface host_bus_if;
  logic       ale;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       upper_address_bit;
  logic [7:0] host_bus;
  logic       host_bus_oe;
  logic [7:0] dev_bus;
  logic       dev_bus_oe;
  logic       dev_ready;
  logic       dev_ready_oe;
  logic [7:0] shared_addr_data_bus;
  logic       ready;

  // wire level: pull-up when nobody drives
  assign shared_addr_data_bus = host_bus_oe ? host_bus : (dev_bus_oe ? dev_bus : 8'hff);
  assign ready                = dev_ready_oe ? dev_ready : 1'b1;

  modport host_end (output ale, cs_n, rd_n, wr_n, upper_address_bit, host_bus, host_bus_oe,
                    input shared_addr_data_bus, ready);
  modport device_end (input ale, cs_n, rd_n, wr_n, upper_address_bit, shared_addr_data_bus,
                      output dev_bus, dev_bus_oe, dev_ready, dev_ready_oe);
endinterface : host_bus_if

// file: common/host_bus_pkg.sv
package host_bus_pkg;

  // clock and counter geometry
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W         = 11;

  // device wait figures in ns
  localparam int READ_BASE_NS  = 600;
  localparam int READ_MAX_NS   = 1220;
  localparam int PEN_R2_NS     = 65;
  localparam int PEN_W1_NS     = 310;
  localparam int PEN_W2_NS     = 620;
  localparam int WRITE_LOW_NS  = 100;
  localparam int WRITE_MAX_NS  = 900;
  localparam int EXT_EVEN_NS   = 200;
  localparam int EXT_GROUP_NS  = 775;

  // host gap figures in ns
  localparam int GAP_R2_NS     = 325;
  localparam int GAP_W1_NS     = 600;
  localparam int GAP_W2_NS     = 900;
  localparam int GAP_ANY_NS    = 10;
  localparam int ALE_HIGH_NS   = 20;

  // longest times round down, least times round up
  localparam logic [CNT_W-1:0] READ_BASE_CYC = CNT_W'(READ_BASE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_MAX_CYC  = CNT_W'(READ_MAX_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PEN_R2_CYC    = CNT_W'(PEN_R2_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PEN_W1_CYC    = CNT_W'(PEN_W1_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PEN_W2_CYC    = CNT_W'(PEN_W2_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WRITE_LOW_CYC = CNT_W'(WRITE_LOW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EXT_EVEN_CYC  = CNT_W'(EXT_EVEN_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EXT_GROUP_CYC = CNT_W'(EXT_GROUP_NS / CLK_PERIOD_NS);
  localparam int RU = CLK_PERIOD_NS - 1;
  localparam logic [CNT_W-1:0] GAP_R2_CYC    = CNT_W'((GAP_R2_NS + RU) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GAP_W1_CYC    = CNT_W'((GAP_W1_NS + RU) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GAP_W2_CYC    = CNT_W'((GAP_W2_NS + RU) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GAP_ANY_CYC   = CNT_W'((GAP_ANY_NS + RU) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ALE_HIGH_CYC  = CNT_W'((ALE_HIGH_NS + RU) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] AGE_SAT       = {CNT_W{1'b1}};

  // transmit terminal port gap arrangement
  typedef enum logic [1:0] {
    GAP_NONE    = 2'b00,
    GAP_EVEN    = 2'b01,
    GAP_GROUPED = 2'b10
  } gap_mode_type;

  // pin sample as seen by the device
  typedef struct packed {
    logic       ale;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       upper;
    logic [7:0] bus;
  } pin_type;

  localparam pin_type PIN_IDLE = '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                   upper: 1'b0, bus: 8'h00};

  // extra wait for payload-only terminal mode
  function automatic logic [CNT_W-1:0] ext_cycles(input gap_mode_type mode);
    case (mode)
      GAP_EVEN:    ext_cycles = EXT_EVEN_CYC;
      GAP_GROUPED: ext_cycles = EXT_GROUP_CYC;
      default:     ext_cycles = '0;
    endcase
  endfunction : ext_cycles

endpackage : host_bus_pkg

// file: hdl/host_bus_device.sv
`timescale 1ns/1ps
// What this block does
// - address captured when latch strobe falls
// - ready driven only while select low
// - read: ready low, data, ready high
// - host holds strobe until ready rises
// - read wait 600 ns plus penalty, capped
// - penalty from recent writes and two-byte reads same address
// - host gap after reads, longer two-byte
// - host gap after writes before reads
// - payload mode gaps lengthen all waits
// - linked counter low byte is two-byte
// - strobes count only with select low
// - write ready low at most 900 ns
module host_bus_device
  import host_bus_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // device pins
  host_bus_if.device_end  bus,
  // register file side
  input  wire logic       wide_counter_link_enable_in,
  input  wire logic       counter_low_in,
  input  wire logic [1:0] gap_mode_in,
  input  wire logic [7:0] rsp_rdata_in,
  output logic            req_valid_out,
  output logic            req_write_out,
  output logic [8:0]      addr_out,
  output logic [7:0]      req_wdata_out
);

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_WAIT = 2'b01,
    DEV_HOLD = 2'b10
  } dev_state_type;

  typedef struct packed {
    pin_type          s1;
    pin_type          s2;
    pin_type          prev;
    dev_state_type    st;
    logic             wr;
    logic             two;
    logic [8:0]       addr;
    logic [CNT_W-1:0] cnt;
    logic [8:0]       r2_addr;
    logic [CNT_W-1:0] r2_age;
    logic [8:0]       w1_addr;
    logic [CNT_W-1:0] w1_age;
    logic [8:0]       w2_addr;
    logic [CNT_W-1:0] w2_age;
    logic             ready;
    logic             ready_oe;
    logic [7:0]       data;
    logic             data_oe;
    logic             req_valid;
    logic             req_write;
    logic [7:0]       req_wdata;
  } dev_reg_type;

  localparam dev_reg_type DEV_RESET = '{s1: PIN_IDLE, s2: PIN_IDLE, prev: PIN_IDLE,
                                       st: DEV_IDLE, r2_age: AGE_SAT, w1_age: AGE_SAT,
                                       w2_age: AGE_SAT, ready: 1'b1, default: '0};

  dev_reg_type s;
  dev_reg_type next_s;

  logic             sel;
  logic             ale_fall;
  logic             rd_fall;
  logic             rd_rise;
  logic             wr_fall;
  logic             wr_rise;
  logic             two_now;
  logic [CNT_W-1:0] ext;
  logic [CNT_W-1:0] pen;
  logic [CNT_W-1:0] read_wait;
  logic [CNT_W-1:0] write_wait;

  // remaining penalty once age has passed part of it
  function automatic logic [CNT_W-1:0] left(input logic [CNT_W-1:0] age,
                                            input logic [CNT_W-1:0] lim,
                                            input logic             hit);
    if (!hit || age >= lim) begin
      left = '0;
    end else begin
      left = lim - age;
    end
  endfunction : left

  // edges of the synchronised pins, strobe falls only while selected
  always_comb begin
    sel      = ~s.s2.cs_n;
    ale_fall = s.prev.ale & ~s.s2.ale;
    rd_fall  = sel & s.prev.rd_n & ~s.s2.rd_n;
    wr_fall  = sel & s.prev.wr_n & ~s.s2.wr_n;
    rd_rise  = ~s.prev.rd_n & s.s2.rd_n;
    wr_rise  = ~s.prev.wr_n & s.s2.wr_n;
    two_now  = wide_counter_link_enable_in & counter_low_in;
  end

  // wait lengths for the access now starting
  always_comb begin
    ext = ext_cycles(gap_mode_type'(gap_mode_in));
    pen = left(s.r2_age, PEN_R2_CYC, s.r2_addr == s.addr);
    if (left(s.w1_age, PEN_W1_CYC, s.w1_addr == s.addr) > pen) begin
      pen = left(s.w1_age, PEN_W1_CYC, s.w1_addr == s.addr);
    end
    if (left(s.w2_age, PEN_W2_CYC, s.w2_addr == s.addr) > pen) begin
      pen = left(s.w2_age, PEN_W2_CYC, s.w2_addr == s.addr);
    end
    read_wait = READ_BASE_CYC + pen;
    if (read_wait > READ_MAX_CYC) begin
      read_wait = READ_MAX_CYC;
    end
    read_wait  = read_wait + ext;
    write_wait = WRITE_LOW_CYC + ext;
  end

  // access engine
  always_comb begin
    next_s           = s;
    next_s.s1        = '{ale: bus.ale, cs_n: bus.cs_n, rd_n: bus.rd_n, wr_n: bus.wr_n,
                         upper: bus.upper_address_bit, bus: bus.shared_addr_data_bus};
    next_s.s2        = s.s1;
    next_s.prev      = s.s2;
    next_s.req_valid = 1'b0;
    next_s.ready_oe  = sel;
    // ages of the last two-byte read and the last one- and two-byte writes saturate
    if (s.r2_age != AGE_SAT) begin
      next_s.r2_age = s.r2_age + 1'b1;
    end
    if (s.w1_age != AGE_SAT) begin
      next_s.w1_age = s.w1_age + 1'b1;
    end
    if (s.w2_age != AGE_SAT) begin
      next_s.w2_age = s.w2_age + 1'b1;
    end
    // address taken from the sample still showing the latch high
    if (ale_fall) begin
      next_s.addr = {s.prev.upper, s.prev.bus};
    end
    case (s.st)
      DEV_IDLE: begin
        next_s.ready   = 1'b1;
        next_s.data_oe = 1'b0;
        if (rd_fall) begin
          next_s.ready     = 1'b0;
          next_s.wr        = 1'b0;
          next_s.two       = two_now;
          next_s.cnt       = read_wait;
          next_s.req_valid = 1'b1;
          next_s.req_write = 1'b0;
          next_s.st        = DEV_WAIT;
        end else if (wr_fall) begin
          next_s.ready = 1'b0;
          next_s.wr    = 1'b1;
          next_s.two   = two_now;
          next_s.cnt   = write_wait;
          next_s.st    = DEV_WAIT;
        end
      end
      DEV_WAIT: begin
        next_s.cnt = s.cnt - 1'b1;
        // read data goes out well before ready rises
        if (s.req_valid && !s.wr) begin
          next_s.data    = rsp_rdata_in;
          next_s.data_oe = 1'b1;
        end
        if (s.cnt <= 1) begin
          next_s.ready = 1'b1;
          next_s.st    = DEV_HOLD;
          if (s.two && !s.wr) begin
            next_s.r2_addr = s.addr;
            next_s.r2_age  = '0;
          end
        end
      end
      DEV_HOLD: begin
        // wait for the strobe to come back high
        if (rd_rise) begin
          next_s.data_oe = 1'b0;
          next_s.st      = DEV_IDLE;
        end else if (wr_rise) begin
          next_s.req_valid = 1'b1;
          next_s.req_write = 1'b1;
          next_s.req_wdata = s.prev.bus;
          next_s.st        = DEV_IDLE;
          if (s.two) begin
            next_s.w2_addr = s.addr;
            next_s.w2_age  = '0;
          end else begin
            next_s.w1_addr = s.addr;
            next_s.w1_age  = '0;
          end
        end else if (!sel) begin
          next_s.data_oe = 1'b0;
          next_s.st      = DEV_IDLE;
        end
      end
      default: next_s.st = DEV_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // pins and register file side
  assign bus.dev_ready    = s.ready;
  assign bus.dev_ready_oe = s.ready_oe;
  assign bus.dev_bus      = s.data;
  assign bus.dev_bus_oe   = s.data_oe;
  assign req_valid_out    = s.req_valid;
  assign req_write_out    = s.req_write;
  assign addr_out         = s.addr;
  assign req_wdata_out    = s.req_wdata;

endmodule : host_bus_device

// file: hdl/host_bus_master.sv
`timescale 1ns/1ps
module host_bus_master
  import host_bus_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // command side
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_write_in,
  input  wire logic       cmd_two_byte_in,
  input  wire logic [8:0] cmd_addr_in,
  input  wire logic [7:0] cmd_wdata_in,
  input  wire logic [1:0] gap_mode_in,
  output logic            cmd_ready_out,
  output logic            rsp_valid_out,
  output logic [7:0]      rsp_rdata_out,
  // device pins
  host_bus_if.host_end    bus
);

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_GAP    = 3'b001,
    H_ADDR   = 3'b010,
    H_LATCH  = 3'b011,
    H_STROBE = 3'b100,
    H_DONE   = 3'b101
  } host_state_type;

  typedef enum logic [2:0] {
    LAST_NONE   = 3'b000,
    LAST_READ   = 3'b001,
    LAST_READ2  = 3'b010,
    LAST_WRITE1 = 3'b011,
    LAST_WRITE2 = 3'b100
  } last_type;

  typedef struct packed {
    host_state_type   st;
    logic [1:0]       rdy_sync;
    logic [7:0]       bus1;
    logic [7:0]       bus2;
    logic             seen_low;
    logic             wr;
    logic             two;
    logic [8:0]       addr;
    logic [7:0]       wdata;
    last_type         last;
    logic [8:0]       last_addr;
    logic [CNT_W-1:0] since;
    logic [CNT_W-1:0] cnt;
    logic             ale;
    logic             cs_n;
    logic             rd_n;
    logic             wr_n;
    logic             upper;
    logic [7:0]       bus_out;
    logic             bus_oe;
    logic             cmd_ready;
    logic             rsp_valid;
    logic [7:0]       rsp_rdata;
  } host_reg_type;

  localparam host_reg_type HOST_RESET = '{st: H_IDLE, rdy_sync: 2'b11, last: LAST_NONE,
                                         since: AGE_SAT, cs_n: 1'b1, rd_n: 1'b1,
                                         wr_n: 1'b1, default: '0};

  host_reg_type s;
  host_reg_type next_s;
  logic [CNT_W-1:0] need;

  // least gap before the pending access, measured from the last read or write strobe rise
  always_comb begin
    need = GAP_ANY_CYC;
    if (!s.wr && s.addr != s.last_addr) begin
      case (s.last)
        LAST_READ2:  need = GAP_R2_CYC + ext_cycles(gap_mode_type'(gap_mode_in));
        LAST_WRITE1: need = GAP_W1_CYC + ext_cycles(gap_mode_type'(gap_mode_in));
        LAST_WRITE2: need = GAP_W2_CYC + ext_cycles(gap_mode_type'(gap_mode_in));
        default:     need = GAP_ANY_CYC;
      endcase
    end
  end

  // access sequencer
  always_comb begin
    next_s           = s;
    next_s.rdy_sync  = {s.rdy_sync[0], bus.ready};
    next_s.bus1      = bus.shared_addr_data_bus;
    next_s.bus2      = s.bus1;
    next_s.rsp_valid = 1'b0;
    if (s.since != AGE_SAT) begin
      next_s.since = s.since + 1'b1;
    end
    case (s.st)
      H_IDLE: begin
        if (cmd_valid_in && s.cmd_ready) begin
          next_s.cmd_ready = 1'b0;
          next_s.wr        = cmd_write_in;
          next_s.two       = cmd_two_byte_in;
          next_s.addr      = cmd_addr_in;
          next_s.wdata     = cmd_wdata_in;
          next_s.st        = H_GAP;
        end else begin
          next_s.cmd_ready = 1'b1;
        end
      end
      H_GAP: begin
        if (s.since >= need) begin
          next_s.st      = H_ADDR;
          next_s.ale     = 1'b1;
          next_s.cs_n    = 1'b0;
          next_s.bus_out = s.addr[7:0];
          next_s.upper   = s.addr[8];
          next_s.bus_oe  = 1'b1;
          next_s.cnt     = ALE_HIGH_CYC;
        end
      end
      H_ADDR: begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt <= 1) begin
          next_s.ale = 1'b0;
          next_s.st  = H_LATCH;
        end
      end
      H_LATCH: begin
        // address held one cycle past the latch fall, then the strobe
        next_s.seen_low = 1'b0;
        next_s.st       = H_STROBE;
        if (s.wr) begin
          next_s.bus_out = s.wdata;
          next_s.wr_n    = 1'b0;
        end else begin
          next_s.bus_oe = 1'b0;
          next_s.rd_n   = 1'b0;
        end
      end
      H_STROBE: begin
        if (!s.rdy_sync[1]) begin
          next_s.seen_low = 1'b1;
        end
        if (s.seen_low && s.rdy_sync[1]) begin
          // strobe held until ready is back high
          next_s.rd_n      = 1'b1;
          next_s.wr_n      = 1'b1;
          next_s.since     = '0;
          next_s.last_addr = s.addr;
          next_s.st        = H_DONE;
          if (s.wr) begin
            next_s.last = s.two ? LAST_WRITE2 : LAST_WRITE1;
          end else begin
            next_s.last      = s.two ? LAST_READ2 : LAST_READ;
            next_s.rsp_valid = 1'b1;
            next_s.rsp_rdata = s.bus2;
          end
        end
      end
      H_DONE: begin
        // select and latch stay put until the strobe is already high
        next_s.cs_n   = 1'b1;
        next_s.bus_oe = 1'b0;
        next_s.upper  = 1'b0;
        next_s.st     = H_IDLE;
      end
      default: next_s.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // pins and user outputs
  assign bus.ale               = s.ale;
  assign bus.cs_n              = s.cs_n;
  assign bus.rd_n              = s.rd_n;
  assign bus.wr_n              = s.wr_n;
  assign bus.upper_address_bit = s.upper;
  assign bus.host_bus          = s.bus_out;
  assign bus.host_bus_oe       = s.bus_oe;
  assign cmd_ready_out         = s.cmd_ready;
  assign rsp_valid_out         = s.rsp_valid;
  assign rsp_rdata_out         = s.rsp_rdata;

endmodule : host_bus_master

// file: verification/host_bus_chk.sv
`timescale 1ns/1ps
module host_bus_chk
  import host_bus_pkg::*;
(
  // clock, reset and terminal mode
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] gap_mode_in,
  // interface wires
  input  wire logic       ale,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       dev_bus_oe,
  input  wire logic       dev_ready_oe,
  input  wire logic       ready
);
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] ext;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // extra wait of the current terminal mode
  always_comb begin
    ext = (gap_mode_in == GAP_EVEN) ? EXT_EVEN_CYC :
          ((gap_mode_in == GAP_GROUPED) ? EXT_GROUP_CYC : '0);
  end

  // length of the current ready low stretch
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= ready ? '0 : low_cnt + 1'b1;
    end
  end

  AST_READY_ONLY_SELECTED: assert property (!ready |-> !cs_n)
    else $error("ready low while deselected");
  AST_READY_OE_ON: assert property ($fell(cs_n) |-> ##[1:4] dev_ready_oe)
    else $error("ready not driven after select");
  AST_READY_OE_OFF: assert property ($rose(cs_n) |-> ##[1:4] !dev_ready_oe)
    else $error("ready still driven after deselect");
  AST_READ_WAIT_START: assert property ($fell(rd_n) && !cs_n |-> ##[1:5] !ready)
    else $error("no wait after read strobe");
  AST_READ_DATA_FIRST: assert property ($rose(ready) && !rd_n |-> dev_bus_oe && $past(dev_bus_oe))
    else $error("read data not driven before ready");
  AST_READ_DATA_RELEASE: assert property ($rose(rd_n) |-> ##[1:6] !dev_bus_oe)
    else $error("read data not released");
  AST_READ_WAIT_MAX: assert property (!ready && !rd_n |-> low_cnt <= READ_MAX_CYC + ext)
    else $error("read wait too long");
  AST_WRITE_WAIT_MAX: assert property (!ready && !wr_n |-> int'(low_cnt) <= WRITE_MAX_NS / CLK_PERIOD_NS + int'(ext))
    else $error("write wait too long");
  AST_STROBE_AFTER_ALE: assert property (!rd_n || !wr_n |-> !ale)
    else $error("strobe low while latch strobe high");
  AST_STROBE_SELECTED: assert property (!rd_n || !wr_n |-> !cs_n)
    else $error("strobe low without select");
  AST_STROBE_HELD: assert property ($rose(rd_n) || $rose(wr_n) |-> $past(ready) && $past(ready, 2))
    else $error("strobe released before ready");
  AST_ALE_WIDTH: assert property ($rose(ale) |=> ale)
    else $error("latch strobe too short");
endmodule : host_bus_chk

// file: verification/tb_muxed_host_bus_handshake.sv
`timescale 1ns/1ps
module tb_muxed_host_bus_handshake
  import host_bus_pkg::*;
();
  logic         clk_sys_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         cmd_valid_in = 1'b0, cmd_write_in = 1'b0, cmd_two_byte_in = 1'b0;
  logic [8:0]   cmd_addr_in = 9'h000;
  logic [7:0]   cmd_wdata_in = 8'h00, reg_rdata = 8'h00, host_rdata, req_wdata;
  gap_mode_type gap_mode = GAP_NONE;
  logic         link_en = 1'b0;
  logic         counter_low;
  logic         cmd_ready, rsp_valid, req_valid, req_write;
  logic [8:0]   addr, ra [6];
  logic [7:0]   mem [512], shadow [512];
  logic [17:0]  exp_req [$];
  logic [7:0]   exp_rd [$];
  int           lo_q [$], hi_q [$];
  int           mismatches = 0, checked = 0, low_len = 0, since_rdy = 0, gap_lo = 0;
  logic         rd_prev = 1'b1;

  host_bus_if bus_if ();
  host_bus_master i_host_bus_master (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
    .cmd_two_byte_in(cmd_two_byte_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .gap_mode_in(gap_mode), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_rdata_out(host_rdata), .bus(bus_if));
  host_bus_device i_host_bus_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(bus_if),
    .wide_counter_link_enable_in(link_en), .counter_low_in(counter_low),
    .gap_mode_in(gap_mode), .rsp_rdata_in(reg_rdata), .req_valid_out(req_valid),
    .req_write_out(req_write), .addr_out(addr), .req_wdata_out(req_wdata));
  host_bus_chk i_host_bus_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .gap_mode_in(gap_mode), .ale(bus_if.ale), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .dev_bus_oe(bus_if.dev_bus_oe), .dev_ready_oe(bus_if.dev_ready_oe),
    .ready(bus_if.ready));

  // clock
  always #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;

  // register file behind the device
  always @(posedge clk_sys_in) begin
    if (req_valid && req_write) mem[addr] <= req_wdata;
    reg_rdata   <= mem[addr];
  end

  // counter low byte decode: the strobe fall follows the address latch by one cycle only
  assign counter_low = addr[8] & ~addr[0];

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // scoreboard: oldest note against each result as it appears
  always @(posedge clk_sys_in) begin
    if (!rst_in) begin
      if (req_valid) check("request", {req_write, addr, req_write ? req_wdata : 8'h00}, exp_req.pop_front());
      if (rsp_valid) check("read_data", host_rdata, exp_rd.pop_front());
      if (!bus_if.ready) begin
        low_len++;
        since_rdy = 0;
      end else begin
        since_rdy++;
        if (low_len > 0) begin
          check("ready_low", low_len >= lo_q[0] && low_len <= hi_q[0], 1);
          void'(lo_q.pop_front());
          void'(hi_q.pop_front());
          low_len = 0;
        end
      end
      if (!bus_if.rd_n && rd_prev && gap_lo > 0) check("read_gap", since_rdy >= gap_lo, 1);
      if (!bus_if.rd_n && rd_prev) gap_lo = 0;
      rd_prev = bus_if.rd_n;
    end
  end

  // one host command with its expected wait window and gap
  task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d,
                        input gap_mode_type m, input logic lk, input int pen,
                        input int slack, input int gap);
    int n;
    int ext;
    int c;
    @(posedge clk_sys_in);
    for (n = 0; n < 3000 && cmd_ready !== 1'b1; n++) @(posedge clk_sys_in);
    if (n == 3000) mismatches++;  // host never ready again: counts as a failure
    ext = (m == GAP_EVEN) ? int'(EXT_EVEN_CYC) : ((m == GAP_GROUPED) ? int'(EXT_GROUP_CYC) : 0);
    c = w ? int'(WRITE_LOW_CYC) : int'(READ_BASE_CYC) + pen;
    if (!w && c > int'(READ_MAX_CYC)) c = int'(READ_MAX_CYC);
    lo_q.push_back(c + ext - 1 - slack);
    hi_q.push_back(c + ext + 1);
    gap_lo = (gap > 0) ? gap + ext : 0;
    exp_req.push_back({w, a, w ? d : 8'h00});
    if (w) shadow[a] = d;
    else exp_rd.push_back(shadow[a]);
    gap_mode        <= m;
    link_en         <= lk;
    cmd_valid_in    <= 1'b1;
    cmd_write_in    <= w;
    cmd_two_byte_in <= lk & a[8] & ~a[0];
    cmd_addr_in     <= a;
    cmd_wdata_in    <= d;
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
  endtask : access

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // cut a hang short: the tests need far fewer cycles
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    int n;
    for (int i = 0; i < 512; i++) begin
      mem[i]    = 8'(i) ^ 8'ha5;
      shadow[i] = 8'(i) ^ 8'ha5;
    end
    void'($urandom(62));
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // every terminal mode: write, then read of another address
    for (int k = 0; k < 3; k++) begin
      access(1'b1, 9'h010 + 9'(k), 8'h3c, gap_mode_type'(k), 1'b0, 0, 0, 0);
      access(1'b0, 9'h020 + 9'(k), 8'h00, gap_mode_type'(k), 1'b0, 0, 0, int'(GAP_W1_CYC));
    end
    // linked counter: two-byte write penalty and gaps, then one-byte
    access(1'b1, 9'h1f0, 8'h81, GAP_NONE, 1'b1, 0, 0, 0);
    access(1'b0, 9'h1f0, 8'h00, GAP_NONE, 1'b1, int'(PEN_W2_CYC), 20, 0);
    access(1'b0, 9'h022, 8'h00, GAP_NONE, 1'b1, 0, 0, int'(GAP_R2_CYC));
    access(1'b1, 9'h1f2, 8'h42, GAP_NONE, 1'b1, 0, 0, 0);
    access(1'b0, 9'h030, 8'h00, GAP_NONE, 1'b1, 0, 0, int'(GAP_W2_CYC));
    access(1'b1, 9'h1f0, 8'h18, GAP_NONE, 1'b0, 0, 0, 0);
    access(1'b0, 9'h1f0, 8'h00, GAP_NONE, 1'b0, int'(PEN_W1_CYC), 20, 0);
    // random writes read back
    for (int i = 0; i < 6; i++) begin
      ra[i] = {1'b0, 3'(i), 5'($urandom)};
      access(1'b1, ra[i], 8'($urandom), GAP_NONE, 1'b0, 0, 0, 0);
    end
    for (int i = 0; i < 6; i++) access(1'b0, ra[i], 8'h00, GAP_NONE, 1'b0, 0, 0, 0);
    for (n = 0; n < 3000 && (lo_q.size() > 0 || exp_rd.size() > 0); n++) @(posedge clk_sys_in);
    check("pending", exp_req.size() + exp_rd.size() + lo_q.size(), 0);
    final_report();
  end
endmodule : tb_muxed_host_bus_handshake
